// file: logic/wdt_reset_pkg.sv
// Purpose: Shared constants, types and helpers of the watchdog and reset-key block
// Assumes: 32-bit AHB-Lite register bus, 40 MHz system clock
// Notes:   Register offsets are byte addresses of aligned words
package wdt_reset_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_FREQ_KHZ         = 40000;
  localparam int unsigned SOFT_RESET_DELAY_US  = 50;
  localparam int unsigned SOFT_RESET_CYCLES    = SOFT_RESET_DELAY_US * CLK_FREQ_KHZ / 1000;
  localparam int unsigned WDT_CNT_W            = 18;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] ADDR_WDT_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CAUSE      = 8'h04;
  localparam logic [7:0] ADDR_GUARD      = 8'h08;
  localparam logic [7:0] ADDR_STATE      = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h14;

  localparam logic [7:0] WDT_CTRL_POR    = 8'h53;
  localparam logic [4:0] KEY_ENABLE      = 5'h0A;
  localparam logic [4:0] KEY_DISABLE     = 5'h15;
  localparam logic [7:0] GUARD_POR       = 8'h55;
  localparam logic [7:0] GUARD_ALT       = 8'hAA;
  localparam logic [7:0] PORT_POR_VALUE  = 8'hFF;

  // Interrupt status bit positions
  localparam int unsigned IRQ_TIMEOUT    = 0;
  localparam int unsigned IRQ_WDT_KEY    = 1;
  localparam int unsigned IRQ_GUARD_KEY  = 2;
  localparam int unsigned IRQ_W          = 3;

  typedef struct packed {
    logic [4:0] wdt_enable_key;
    logic [2:0] wdt_period_sel;
  } wdt_ctrl_t;

  typedef struct packed {
    logic [3:0] zero;
    logic       reset_key_corrupt_flag;
    logic       low_voltage_flag;
    logic       voltage_key_corrupt_flag;
    logic       wdt_key_corrupt_flag;
  } cause_flags_t;

  // Period code to timeout exponent
  function automatic logic [4:0] period_exp(input logic [2:0] sel);
    unique case (sel)
      3'h0:    period_exp = 5'd8;
      3'h1:    period_exp = 5'd10;
      3'h2:    period_exp = 5'd12;
      3'h3:    period_exp = 5'd14;
      3'h4:    period_exp = 5'd15;
      3'h5:    period_exp = 5'd16;
      3'h6:    period_exp = 5'd17;
      default: period_exp = 5'd18;
    endcase
  endfunction

endpackage

// file: logic/level_sync.sv
// Purpose: Two-flop synchroniser for a level from another domain
// Assumes: Input is a slowly changing level or clock
// Notes:   First flop feeds only the second
`timescale 1ns/1ps
module level_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Level
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // level_sync

// file: logic/wdt_counter.sv
// Purpose: Watchdog counter advanced by rising edges of the slow oscillator
// Assumes: slow_lvl is already synchronised to clk
// Notes:   overflow is a one-cycle pulse; counter restarts from zero after it
`timescale 1ns/1ps
module wdt_counter
  import wdt_reset_pkg::*;
#(
  parameter int unsigned CNT_W = WDT_CNT_W
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Control
  input  wire logic       slow_lvl,
  input  wire logic       enable,
  input  wire logic       clear,
  input  wire logic [2:0] period_sel,
  // Event
  output logic            overflow
);

  logic             slow_prev_q;
  logic [CNT_W-1:0] count_q;
  logic             tick;
  logic [CNT_W-1:0] limit;

  assign tick  = slow_lvl & ~slow_prev_q;
  assign limit = CNT_W'((CNT_W+1)'(1) << period_exp(period_sel)) - CNT_W'(1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slow_prev_q <= 1'b0;
    end else begin
      slow_prev_q <= slow_lvl;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q  <= '0;
      overflow <= 1'b0;
    end else begin
      overflow <= 1'b0;
      if (clear) begin
        count_q <= '0;
      end else if (enable && tick) begin
        if (count_q >= limit) begin
          count_q  <= '0;
          overflow <= 1'b1;
        end else begin
          count_q <= count_q + CNT_W'(1);
        end
      end
    end
  end

endmodule // wdt_counter

// file: logic/wdt_reset_keys.sv
// Purpose: Watchdog, key-protected control and reset-guard registers, reset cause flags
// Assumes: Core supplies one-cycle clear/halt pulses and a sleep level on clk
// Notes:   Reset outputs are one-cycle request pulses
// Notes on behaviour
// - Watchdog counts edges of the slow internal oscillator, timeout a power of two.
// - Period codes 0..7 give 2^8,10,12,14,15,16,17,18 slow cycles.
// - Key 10101B disables the watchdog, key 01010B enables it.
// - Any other enable key causes a full reset after the soft reset delay.
// - Watchdog control register resets to 01010011, watchdog enabled.
// - Overflow in normal running resets the device and sets expired flag.
// - Overflow in sleep or idle sets expired flag, resets only PC and SP.
// - Counter cleared by bad key, clear instruction, or HALT.
// - Bad enable key reset sets key corrupt flag; only software clears it.
// - Guard register values 55h or AAh do nothing; others reset after delay.
// - Guard register resets to 01010101B.
// - Bad guard value reset sets guard corrupt flag; only software clears it.
// - Cause flags bits 7..4 read zero; corrupt flags zero after power-on.
// - Power-on clears program counter and sets port registers to all ones.
// - HALT clears counter, which runs on only if watchdog enabled.
// - Sleep watchdog reset shows expired and powerdown; normal sets expired only.
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module wdt_reset_keys
  import wdt_reset_pkg::*;
#(
  parameter int unsigned SOFT_RESET_CNT = SOFT_RESET_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Slow oscillator pin
  input  wire logic        slow_internal_osc,
  // Core events
  input  wire logic        clear_watchdog_instr,
  input  wire logic        halt_instr,
  input  wire logic        sleep_mode,
  // Reset and interrupt outputs
  output logic             device_reset,
  output logic             pc_sp_reset,
  output logic             por_init,
  output logic [7:0]       port_init_value,
  output logic             irq
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  typedef enum logic [0:0] {SR_IDLE, SR_WAIT} sr_state_t;

  localparam int unsigned DLY_W = $clog2(SOFT_RESET_CNT + 1) + 1;

  wdt_ctrl_t          wdt_ctrl_q;
  cause_flags_t       cause_q;
  logic [7:0]         guard_q;
  logic               expired_q;
  logic               powerdown_q;
  logic [IRQ_W-1:0]   irq_stat_q;
  logic [IRQ_W-1:0]   irq_mask_q;
  sr_state_t          sr_state_q;
  logic [DLY_W-1:0]   dly_q;
  logic               src_wdt_q;
  logic               src_guard_q;
  logic               sr_fire;
  logic               ovf;
  logic               slow_lvl;
  logic               wdt_en;
  logic               wdt_key_bad;
  logic               guard_bad;
  logic               ap_take;
  logic               dp_wr_q;
  logic               dp_rd_q;
  logic               rd_wait_q;
  logic [7:0]         dp_addr_q;
  logic               wr_ctrl;
  logic               wr_cause;
  logic               wr_guard;
  logic               wr_stat;
  logic               wr_mask;
  logic [IRQ_W-1:0]   irq_set;
  logic               ovf_normal;
  logic               ovf_sleep;

  // ==========================================================================
  // Key decoding
  // ==========================================================================
  assign wdt_en      = wdt_ctrl_q.wdt_enable_key == KEY_ENABLE;
  assign wdt_key_bad = wdt_ctrl_q.wdt_enable_key != KEY_ENABLE
                    && wdt_ctrl_q.wdt_enable_key != KEY_DISABLE;
  assign guard_bad   = guard_q != GUARD_POR && guard_q != GUARD_ALT;
  assign ovf_normal  = ovf & ~sleep_mode;
  assign ovf_sleep   = ovf & sleep_mode;

  // ==========================================================================
  // Slow clock and counter
  // ==========================================================================
  level_sync u_slow_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (slow_internal_osc),
    .sync_out (slow_lvl)
  );

  wdt_counter #(
    .CNT_W (WDT_CNT_W)
  ) u_counter (
    .clk        (clk),
    .rst_b      (rst_b),
    .slow_lvl   (slow_lvl),
    .enable     (wdt_en),
    .clear      (clear_watchdog_instr | halt_instr | wdt_key_bad),
    .period_sel (wdt_ctrl_q.wdt_period_sel),
    .overflow   (ovf)
  );

  // ==========================================================================
  // AHB-Lite slave
  // ==========================================================================
  assign ap_take   = hsel & htrans[1] & hready;
  assign hreadyout = ~(dp_rd_q & ~rd_wait_q);
  assign hresp     = 1'b0;
  assign wr_ctrl   = dp_wr_q && dp_addr_q == ADDR_WDT_CTRL;
  assign wr_cause  = dp_wr_q && dp_addr_q == ADDR_CAUSE;
  assign wr_guard  = dp_wr_q && dp_addr_q == ADDR_GUARD;
  assign wr_stat   = dp_wr_q && dp_addr_q == ADDR_IRQ_STAT;
  assign wr_mask   = dp_wr_q && dp_addr_q == ADDR_IRQ_MASK;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dp_wr_q   <= 1'b0;
      dp_rd_q   <= 1'b0;
      rd_wait_q <= 1'b0;
      dp_addr_q <= 8'h00;
    end else begin
      if (hreadyout) begin
        dp_wr_q   <= ap_take & hwrite;
        dp_rd_q   <= ap_take & ~hwrite;
        rd_wait_q <= 1'b0;
        if (ap_take) begin
          dp_addr_q <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
        end
      end else begin
        rd_wait_q <= 1'b1;
      end
    end
  end

  // Read data latched in the wait cycle so a preceding write is visible
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (dp_rd_q && !rd_wait_q) begin
      unique case (dp_addr_q)
        ADDR_WDT_CTRL: hrdata <= {24'h000000, wdt_ctrl_q};
        ADDR_CAUSE:    hrdata <= {24'h000000, 4'h0, cause_q[3:0]};
        ADDR_GUARD:    hrdata <= {24'h000000, guard_q};
        ADDR_STATE:    hrdata <= {30'h00000000, powerdown_q, expired_q};
        ADDR_IRQ_STAT: hrdata <= {29'h00000000, irq_stat_q};
        ADDR_IRQ_MASK: hrdata <= {29'h00000000, irq_mask_q};
        default:       hrdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // Key-protected registers
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_ctrl_q <= WDT_CTRL_POR;
    end else if (sr_fire && src_wdt_q) begin
      wdt_ctrl_q <= WDT_CTRL_POR;
    end else if (wr_ctrl) begin
      wdt_ctrl_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      guard_q <= GUARD_POR;
    end else if (sr_fire && src_guard_q) begin
      guard_q <= GUARD_POR;
    end else if (wr_guard) begin
      guard_q <= hwdata[7:0];
    end
  end

  // ==========================================================================
  // Soft reset delay
  // ==========================================================================
  assign sr_fire = sr_state_q == SR_WAIT && dly_q == '0;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sr_state_q  <= SR_IDLE;
      dly_q       <= '0;
      src_wdt_q   <= 1'b0;
      src_guard_q <= 1'b0;
    end else begin
      unique case (sr_state_q)
        SR_IDLE: begin
          if (wdt_key_bad || guard_bad) begin
            sr_state_q  <= SR_WAIT;
            dly_q       <= DLY_W'(SOFT_RESET_CNT - 1);
            src_wdt_q   <= wdt_key_bad;
            src_guard_q <= guard_bad;
          end
        end
        SR_WAIT: begin
          src_wdt_q   <= src_wdt_q | wdt_key_bad;
          src_guard_q <= src_guard_q | guard_bad;
          if (dly_q == '0) begin
            sr_state_q <= SR_IDLE;
          end else begin
            dly_q <= dly_q - DLY_W'(1);
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Reset outputs
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      device_reset <= 1'b0;
      pc_sp_reset  <= 1'b0;
    end else begin
      device_reset <= sr_fire | ovf_normal;
      pc_sp_reset  <= ovf_sleep;
    end
  end

  // Held high through power-on reset and the first cycle after release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      por_init        <= 1'b1;
      port_init_value <= PORT_POR_VALUE;
    end else begin
      por_init        <= 1'b0;
      port_init_value <= PORT_POR_VALUE;
    end
  end

  // ==========================================================================
  // Cause flags, set wins over software clear
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cause_q <= '0;
    end else begin
      cause_q.zero <= 4'h0;
      cause_q.reset_key_corrupt_flag <= (sr_fire & src_guard_q)
        | (cause_q.reset_key_corrupt_flag & ~(wr_cause & ~hwdata[3]));
      cause_q.low_voltage_flag <= cause_q.low_voltage_flag & ~(wr_cause & ~hwdata[2]);
      cause_q.voltage_key_corrupt_flag <= cause_q.voltage_key_corrupt_flag
        & ~(wr_cause & ~hwdata[1]);
      cause_q.wdt_key_corrupt_flag <= (sr_fire & src_wdt_q)
        | (cause_q.wdt_key_corrupt_flag & ~(wr_cause & ~hwdata[0]));
    end
  end

  // ==========================================================================
  // Expired and powerdown flags
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      expired_q   <= 1'b0;
      powerdown_q <= 1'b0;
    end else begin
      if (ovf) begin
        expired_q <= 1'b1;
      end else if (halt_instr || clear_watchdog_instr) begin
        expired_q <= 1'b0;
      end
      if (halt_instr) begin
        powerdown_q <= 1'b1;
      end else if (clear_watchdog_instr) begin
        powerdown_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Interrupts
  // ==========================================================================
  assign irq_set = {sr_fire & src_guard_q, sr_fire & src_wdt_q, ovf};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_set | (irq_stat_q & ~({IRQ_W{wr_stat}} & hwdata[IRQ_W-1:0]));
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_q <= '0;
    end else if (wr_mask) begin
      irq_mask_q <= hwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule // wdt_reset_keys

// file: testbench/wdt_reset_keys_assertions.sv
// Purpose: Port checker of the watchdog and reset-key block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Attached to the design top by bind below
`timescale 1ns/1ps
module wdt_reset_keys_chk
  import wdt_reset_pkg::*;
#(
  parameter int unsigned SOFT_RESET_CNT = SOFT_RESET_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  // Events
  input  wire logic        sleep_mode,
  input  wire logic        device_reset,
  input  wire logic        pc_sp_reset,
  input  wire logic        por_init,
  input  wire logic [7:0]  port_init_value,
  input  wire logic        irq
);
  // ==========================================================================
  // Write data phase tracking
  // ==========================================================================
  localparam int SR_DLY = SOFT_RESET_CNT + 2;
  logic       wr_q;
  logic [7:0] addr_q;
  logic [4:0] key_w;

  assign key_w = hwdata[7:3];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      wr_q   <= hsel && htrans[1] && hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_bus_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not two cycles");
  a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_reset_pulse: assert property (device_reset |=> !device_reset)
    else $error("device reset longer than one cycle");
  a_sleep_pcsp: assert property (pc_sp_reset |-> $past(sleep_mode) ##1 !pc_sp_reset)
    else $error("partial reset outside sleep or too long");
  a_one_reset: assert property (!(device_reset && pc_sp_reset))
    else $error("full and partial reset together");
  a_ports_high: assert property (port_init_value == PORT_POR_VALUE)
    else $error("port init value wrong");
  a_por_once: assert property (por_init |=> !por_init)
    else $error("power-on init held too long");
  a_wkey_delay: assert property (wr_q && addr_q == ADDR_WDT_CTRL && key_w != KEY_ENABLE
    && key_w != KEY_DISABLE |-> ##SR_DLY device_reset)
    else $error("bad enable key reset timing wrong");
  a_gkey_delay: assert property (wr_q && addr_q == ADDR_GUARD && hwdata[7:0] != GUARD_POR
    && hwdata[7:0] != GUARD_ALT |-> ##SR_DLY device_reset)
    else $error("bad guard value reset timing wrong");
  a_mask_quiet: assert property (wr_q && addr_q == ADDR_IRQ_MASK && hwdata[2:0] == 3'h0
    |-> ##3 !irq)
    else $error("interrupt high with all masked");

  c_full_reset: cover property (device_reset);
  c_part_reset: cover property (pc_sp_reset);
  c_irq: cover property (irq);
endmodule // wdt_reset_keys_chk

bind wdt_reset_keys wdt_reset_keys_chk #(.SOFT_RESET_CNT(SOFT_RESET_CNT)) i_chk (
  .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .sleep_mode(sleep_mode), .device_reset(device_reset), .pc_sp_reset(pc_sp_reset),
  .por_init(por_init), .port_init_value(port_init_value), .irq(irq)
);

// file: testbench/tb_wdt_reset_keys.sv
// Purpose: Self-checking bench of the watchdog and reset-key block
// Assumes: Slow oscillator period of 8 system clocks
// Notes:   Soft reset delay shortened to 4 cycles
`timescale 1ns/1ps
module tb_wdt_reset_keys
  import wdt_reset_pkg::*;
;
  localparam int SR = 4;
  logic        clk, rst_b, hsel, hwrite, hreadyout, hresp, osc, clr, halt, slp;
  logic        dev_rst, pcsp, por, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [7:0]  port_v;
  int          bad_count, total_checks, cyc, n_dev, n_pcsp, n0, n1;

  wdt_reset_keys #(.SOFT_RESET_CNT(SR)) i_dut (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .slow_internal_osc(osc), .clear_watchdog_instr(clr), .halt_instr(halt),
    .sleep_mode(slp), .device_reset(dev_rst), .pc_sp_reset(pcsp), .por_init(por),
    .port_init_value(port_v), .irq(irq)
  );

  // ==========================================================================
  // Clocks, event counters, hang guard
  // ==========================================================================
  always #12.5 clk = ~clk;
  always begin
    repeat (4) @(posedge clk);
    osc <= ~osc;
  end
  always @(negedge clk) begin
    if (dev_rst === 1'b1) n_dev++;
    if (pcsp === 1'b1) n_pcsp++;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      stop_test();
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] rdat);
    logic r;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(negedge clk);
      r = hreadyout;
      @(posedge clk);
    end while (r !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(negedge clk);
      r = hreadyout;
      rdat = hrdata;
      @(posedge clk);
    end while (r !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(a, 1'b1, d, x);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(a, 1'b0, 32'h0, x);
    chk(x, e);
  endtask

  task automatic pulse(input logic h);
    if (h) halt <= 1'b1;
    else clr <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    clr  <= 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n * 8) @(posedge clk);
  endtask

  task automatic stop_test;
    $display("checks=%0d bad=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    clk = 0; rst_b = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
    osc = 0; clr = 0; halt = 0; slp = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(ADDR_WDT_CTRL, {24'h0, WDT_CTRL_POR});
    rd(ADDR_GUARD, {24'h0, GUARD_POR});
    rd(ADDR_CAUSE, 32'h0);
    rd(ADDR_STATE, 32'h0);
    chk({24'h0, port_v}, {24'h0, PORT_POR_VALUE});
    chk({31'h0, por}, 32'h0);
    wr(8'h40, 32'h5A);
    rd(8'h40, 32'h0);
    $display("test reset values done");
    wr(ADDR_IRQ_MASK, 32'h7);
    wr(ADDR_WDT_CTRL, {24'h0, KEY_ENABLE, 3'h0});
    n0 = n_dev;
    repeat (3) begin
      ticks(200);
      pulse(1'b0);
    end
    chk(n_dev, n0);
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_WDT_CTRL, {24'h0, KEY_ENABLE, s[2:0]});
      pulse(1'b0);
      n0 = n_dev;
      ticks((s == 0 ? 256 : 1024) - 16);
      chk(n_dev, n0);
      ticks(32);
      chk(n_dev, n0 + 1);
    end
    rd(ADDR_STATE, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_STAT, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("test timeout done");
    wr(ADDR_WDT_CTRL, {24'h0, KEY_ENABLE, 3'h0});
    slp <= 1'b1;
    pulse(1'b1);
    rd(ADDR_STATE, 32'h2);
    n0 = n_dev;
    n1 = n_pcsp;
    ticks(236);
    chk(n_pcsp, n1);
    ticks(32);
    chk(n_pcsp, n1 + 1);
    chk(n_dev, n0);
    rd(ADDR_STATE, 32'h3);
    slp <= 1'b0;
    pulse(1'b0);
    rd(ADDR_STATE, 32'h0);
    $display("test sleep done");
    wr(ADDR_WDT_CTRL, {24'h0, KEY_DISABLE, 3'h0});
    ticks(300);
    chk(n_dev, n0);
    chk(n_pcsp, n1 + 1);
    $display("test disable done");
    wr(ADDR_IRQ_MASK, 32'h0);
    wr(ADDR_WDT_CTRL, 32'h0);
    repeat (SR + 8) @(posedge clk);
    chk(n_dev, n0 + 1);
    rd(ADDR_CAUSE, 32'h1);
    rd(ADDR_WDT_CTRL, {24'h0, WDT_CTRL_POR});
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h2);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_STAT, 32'h2);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_CAUSE, 32'hF);
    rd(ADDR_CAUSE, 32'h1);
    wr(ADDR_CAUSE, 32'h0);
    rd(ADDR_CAUSE, 32'h0);
    $display("test enable key done");
    wr(ADDR_GUARD, {24'h0, GUARD_ALT});
    repeat (SR + 8) @(posedge clk);
    chk(n_dev, n0 + 1);
    rd(ADDR_GUARD, {24'h0, GUARD_ALT});
    wr(ADDR_GUARD, 32'h12);
    repeat (SR + 8) @(posedge clk);
    chk(n_dev, n0 + 2);
    rd(ADDR_CAUSE, 32'h8);
    rd(ADDR_GUARD, {24'h0, GUARD_POR});
    rd(ADDR_IRQ_STAT, 32'h5);
    $display("test guard done");
    stop_test();
  end
endmodule // tb_wdt_reset_keys
